// >>> common/fault_ctrl_pkg.sv
// constants and types for the fault shutdown block
package fault_ctrl_pkg;
    // register addresses (7-bit spi address space)
    localparam logic [6:0] ADDR_CTRL       = 7'h01;
    localparam logic [6:0] ADDR_USER_LO    = 7'h02;
    localparam logic [6:0] ADDR_USER_HI    = 7'h09;
    localparam logic [6:0] ADDR_INT_STAT   = 7'h0c;
    localparam logic [6:0] ADDR_INT_MASK   = 7'h0d;
    localparam logic [6:0] ADDR_UNLOCK_KEY = 7'h2e;
    localparam logic [6:0] ADDR_PROT_PROG  = 7'h2f;
    localparam logic [6:0] ADDR_CUST_LO    = 7'h30;
    localparam logic [6:0] ADDR_CUST_HI    = 7'h35;
    localparam logic [6:0] ADDR_STEP       = 7'h01;

    // field positions and reset values
    localparam int         FAST_SD_EN_BIT  = 0;
    localparam logic [7:0] CTRL_RESET      = 8'h01;
    localparam int         PROTECT_BIT     = 0;
    localparam int         PROGRAM_BIT     = 1;
    localparam logic [7:0] PROT_PROG_RESET = 8'h00;
    localparam logic [7:0] INT_MASK_RESET  = 8'h00;
    localparam logic [7:0] INT_STAT_RESET  = 8'h00;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    // unlock key bytes and key register read values
    localparam logic [7:0] KEY_FIRST         = 8'hba;
    localparam logic [7:0] KEY_SECOND        = 8'hbe;
    localparam logic [7:0] KEY_READ_LOCKED   = 8'h00;
    localparam logic [7:0] KEY_READ_UNLOCKED = 8'h01;

    // interrupt status bit positions
    localparam int INT_BAT_SHUT = 0;
    localparam int INT_THERMAL_SHUTDOWN_FLAG  = 1;
    localparam int INT_THERMAL_WARNING_FLAG  = 2;
    localparam int INT_MIRROR   = 3;
    localparam int INT_ILLUM    = 4;

    // spi command byte
    localparam int         CMD_WRITE_BIT = 7;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [2:0] BIT_FIRST     = 3'h0;
    localparam logic [2:0] BIT_STEP      = 3'h1;

    // synchronised fault vector layout
    localparam int FLT_BAT_SHUT = 0;
    localparam int FLT_THERMAL_SHUTDOWN_FLAG  = 1;
    localparam int FLT_THERMAL_WARNING_FLAG  = 2;
    localparam int FLT_MIR_LO   = 3;
    localparam int FLT_MIR_HI   = 11;
    localparam int FLT_C1_PG    = 12;
    localparam int FLT_C1_OV    = 13;
    localparam int FLT_C2_PG    = 14;
    localparam int FLT_C2_OV    = 15;
    localparam int FLT_W        = 16;
    localparam int LDO_FLT_W    = 4;

    typedef enum logic [2:0] {
        KEY_LOCKED   = 3'b001,
        KEY_HALF     = 3'b010,
        KEY_UNLOCKED = 3'b100
    } unlock_state_t;
endpackage : fault_ctrl_pkg

// >>> core/reg_bank.sv
// byte register bank, registered read
module reg_bank #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // write port
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // read port
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else if (int'(rd_addr_i) < DEPTH) begin
            rd_data_o <= mem_reg[rd_addr_i];
        end else begin
            rd_data_o <= '0;
        end
    end
endmodule : reg_bank

// >>> core/fault_shutdown_nvm_unlock.sv
// fault fast-shutdown, register protection and customer nvm unlock behind an spi register port
//
// Function
// - orderly shutdown path plus separate fast path
// - fast shutdown enable bit, resets enabled
// - fast shutdown starts autonomously on fault
// - only qualifying faults trigger fast shutdown
// - battery, thermal shutdown, mirror, converter overvoltage qualify; thermal warning does not
// - unprotected: all writable registers accept writes
// - protected: only 0x02 to 0x09 and protect_and_program_ctrl (0x2f) writable
// - protect bit lives in register protect_and_program_ctrl
// - registers 0x30 to 0x35 hold customer data
// - unlock writes back to back, else fail
// - customer registers writable only when unlocked
// - other key byte or power cycle relocks
// - key register reads 0x00 locked, 0x01 unlocked
// - unmasked fault status drives interrupt low
// - command msb write flag, low seven address
module fault_shutdown_nvm_unlock
    import fault_ctrl_pkg::*;
#(
    parameter int USER_DEPTH = 8,
    parameter int CUST_DEPTH = 6
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    // spi slave pins
    input  wire logic                 spi_sclk_i,
    input  wire logic                 spi_cs_b_i,
    input  wire logic                 spi_mosi_i,
    output logic                      spi_miso_o,
    output logic                      spi_miso_oe_o,
    // projector enable pin
    input  wire logic                 projector_enable_pin_i,
    // fault flags
    input  wire logic                 battery_low_shutdown_flag_i,
    input  wire logic                 thermal_shutdown_flag_i,
    input  wire logic                 thermal_warning_flag_i,
    input  wire logic                 mirror_power_good_fault_i,
    input  wire logic                 mirror_buck1_power_good_fault_i,
    input  wire logic                 mirror_buck1_overvoltage_fault_i,
    input  wire logic                 mirror_buck2_power_good_fault_i,
    input  wire logic                 mirror_buck2_overvoltage_fault_i,
    input  wire logic [LDO_FLT_W-1:0] mirror_ldo_fault_i,
    input  wire logic                 illum_conv1_power_good_fault_i,
    input  wire logic                 illum_conv1_overvoltage_fault_i,
    input  wire logic                 illum_conv2_power_good_fault_i,
    input  wire logic                 illum_conv2_overvoltage_fault_i,
    // shutdown, interrupt, eeprom
    output logic                      fast_shutdown_o,
    output logic                      orderly_shutdown_o,
    output logic                      int_b_o,
    output logic                      eeprom_program_o
);
    localparam int USER_AW = $clog2(USER_DEPTH);
    localparam int CUST_AW = $clog2(CUST_DEPTH);

    // input synchronisers
    logic [1:0]        sclk_s_reg;
    logic [1:0]        cs_b_s_reg;
    logic [1:0]        mosi_s_reg;
    logic [1:0]        proj_s_reg;
    logic [FLT_W-1:0]  flt_s1_reg;
    logic [FLT_W-1:0]  flt_reg;
    logic              sclk_d_reg;
    logic [FLT_W-1:0]  flt_raw;

    assign flt_raw = {illum_conv2_overvoltage_fault_i, illum_conv2_power_good_fault_i,
                      illum_conv1_overvoltage_fault_i, illum_conv1_power_good_fault_i,
                      mirror_ldo_fault_i,
                      mirror_buck2_overvoltage_fault_i, mirror_buck2_power_good_fault_i,
                      mirror_buck1_overvoltage_fault_i, mirror_buck1_power_good_fault_i,
                      mirror_power_good_fault_i,
                      thermal_warning_flag_i, thermal_shutdown_flag_i, battery_low_shutdown_flag_i};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_s_reg <= 2'h0;
            cs_b_s_reg <= 2'h3;
            mosi_s_reg <= 2'h0;
            proj_s_reg <= 2'h0;
            flt_s1_reg <= '0;
            flt_reg    <= '0;
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_s_reg <= {sclk_s_reg[0], spi_sclk_i};
            cs_b_s_reg <= {cs_b_s_reg[0], spi_cs_b_i};
            mosi_s_reg <= {mosi_s_reg[0], spi_mosi_i};
            proj_s_reg <= {proj_s_reg[0], projector_enable_pin_i};
            flt_s1_reg <= flt_raw;
            flt_reg    <= flt_s1_reg;
            sclk_d_reg <= sclk_s_reg[1];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_active;

    assign sclk_rise    = sclk_s_reg[1] & ~sclk_d_reg;
    assign sclk_fall    = ~sclk_s_reg[1] & sclk_d_reg;
    assign frame_active = ~cs_b_s_reg[1];

    // spi framing with auto-increment
    logic [2:0] bit_cnt_reg;
    logic       in_data_reg;
    logic       wr_op_reg;
    logic [6:0] addr_reg;
    logic [7:0] rx_reg;
    logic [7:0] rx_byte;
    logic       byte_done;
    logic       access;

    assign rx_byte   = {rx_reg[6:0], mosi_s_reg[1]};
    assign byte_done = frame_active & sclk_rise & (bit_cnt_reg == BIT_LAST);
    assign access    = byte_done & in_data_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bit_cnt_reg <= BIT_FIRST;
            in_data_reg <= 1'b0;
            wr_op_reg   <= 1'b0;
            addr_reg    <= 7'h00;
            rx_reg      <= BYTE_ZERO;
        end else if (!frame_active) begin
            bit_cnt_reg <= BIT_FIRST;
            in_data_reg <= 1'b0;
        end else if (sclk_rise) begin
            rx_reg      <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
            if (bit_cnt_reg == BIT_LAST) begin
                if (!in_data_reg) begin
                    in_data_reg <= 1'b1;
                    wr_op_reg   <= rx_byte[CMD_WRITE_BIT];
                    addr_reg    <= rx_byte[6:0];
                end else begin
                    addr_reg    <= addr_reg + ADDR_STEP;
                end
            end
        end
    end

    // write qualification
    logic          in_user;
    logic          in_cust;
    logic          prot_ok;
    logic          lock_ok;
    logic          wr_ok;
    logic          key_wr;
    logic [7:0]    ctrl_reg;
    logic [7:0]    prot_reg;
    logic [7:0]    mask_reg;
    logic [7:0]    stat_reg;
    unlock_state_t key_state_reg;

    assign in_user = (addr_reg >= ADDR_USER_LO) && (addr_reg <= ADDR_USER_HI);
    assign in_cust = (addr_reg >= ADDR_CUST_LO) && (addr_reg <= ADDR_CUST_HI);
    // protect bit stays writable
    assign prot_ok = !prot_reg[PROTECT_BIT] || in_user || (addr_reg == ADDR_PROT_PROG);
    assign lock_ok = !in_cust || (key_state_reg == KEY_UNLOCKED);
    assign wr_ok   = access & wr_op_reg & prot_ok & lock_ok;
    assign key_wr  = wr_ok & (addr_reg == ADDR_UNLOCK_KEY);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_ok && (addr_reg == ADDR_CTRL)) begin
            ctrl_reg <= rx_byte;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prot_reg <= PROT_PROG_RESET;
        end else if (wr_ok && (addr_reg == ADDR_PROT_PROG)) begin
            prot_reg <= rx_byte;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask_reg <= INT_MASK_RESET;
        end else if (wr_ok && (addr_reg == ADDR_INT_MASK)) begin
            mask_reg <= rx_byte;
        end
    end

    // unlock: any access between key bytes aborts
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            key_state_reg <= KEY_LOCKED;
        end else if (access) begin
            unique case (key_state_reg)
                KEY_LOCKED: begin
                    if (key_wr && (rx_byte == KEY_FIRST)) begin
                        key_state_reg <= KEY_HALF;
                    end
                end
                KEY_HALF: begin
                    if (key_wr && (rx_byte == KEY_SECOND)) begin
                        key_state_reg <= KEY_UNLOCKED;
                    end else begin
                        key_state_reg <= KEY_LOCKED;
                    end
                end
                KEY_UNLOCKED: begin
                    if (key_wr) begin
                        key_state_reg <= (rx_byte == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                    end
                end
                default: begin
                    key_state_reg <= KEY_LOCKED;
                end
            endcase
        end
    end

    // fault status and interrupt
    logic [7:0] fault_evt;
    logic [7:0] stat_clr;
    logic       mirror_any;
    logic       fast_trigger;

    assign mirror_any = |flt_reg[FLT_MIR_HI:FLT_MIR_LO];

    always_comb begin
        fault_evt               = BYTE_ZERO;
        fault_evt[INT_BAT_SHUT] = flt_reg[FLT_BAT_SHUT];
        fault_evt[INT_THERMAL_SHUTDOWN_FLAG]  = flt_reg[FLT_THERMAL_SHUTDOWN_FLAG];
        fault_evt[INT_THERMAL_WARNING_FLAG]  = flt_reg[FLT_THERMAL_WARNING_FLAG];
        fault_evt[INT_MIRROR]   = mirror_any;
        fault_evt[INT_ILLUM]    = |flt_reg[FLT_C2_OV:FLT_C1_PG];
    end

    assign stat_clr = (wr_ok && (addr_reg == ADDR_INT_STAT)) ? rx_byte : BYTE_ZERO;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_reg <= INT_STAT_RESET;
        end else begin
            stat_reg <= (stat_reg & ~stat_clr) | fault_evt; // set wins over clear
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_b_o <= 1'b1;
        end else begin
            int_b_o <= ~|(stat_reg & ~mask_reg);
        end
    end

    // power-down paths
    assign fast_trigger = flt_reg[FLT_BAT_SHUT] | flt_reg[FLT_THERMAL_SHUTDOWN_FLAG] | mirror_any
                        | flt_reg[FLT_C1_OV] | flt_reg[FLT_C2_OV];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fast_shutdown_o    <= 1'b0;
            orderly_shutdown_o <= 1'b1;
        end else begin
            orderly_shutdown_o <= ~proj_s_reg[1];
            if (!proj_s_reg[1]) begin
                fast_shutdown_o <= 1'b0;
            end else if (ctrl_reg[FAST_SD_EN_BIT] && fast_trigger) begin
                fast_shutdown_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eeprom_program_o <= 1'b0;
        end else begin
            eeprom_program_o <= prot_reg[PROGRAM_BIT];
        end
    end

    // register banks
    logic [7:0]         user_rd;
    logic [7:0]         cust_rd;
    logic [USER_AW-1:0] user_idx;
    logic [CUST_AW-1:0] cust_idx;
    logic [6:0]         user_off;
    logic [6:0]         cust_off;

    assign user_off = addr_reg - ADDR_USER_LO;
    assign cust_off = addr_reg - ADDR_CUST_LO;
    assign user_idx = user_off[USER_AW-1:0];
    assign cust_idx = cust_off[CUST_AW-1:0];

    reg_bank #(.WIDTH(8), .DEPTH(USER_DEPTH), .AW(USER_AW)) u_user_bank (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (wr_ok & in_user),
        .wr_addr_i (user_idx),
        .wr_data_i (rx_byte),
        .rd_addr_i (user_idx),
        .rd_data_o (user_rd)
    );

    reg_bank #(.WIDTH(8), .DEPTH(CUST_DEPTH), .AW(CUST_AW)) u_cust_bank (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (wr_ok & in_cust),
        .wr_addr_i (cust_idx),
        .wr_data_i (rx_byte),
        .rd_addr_i (cust_idx),
        .rd_data_o (cust_rd)
    );

    // read mux
    logic [7:0] rd_value;

    always_comb begin
        rd_value = BYTE_ZERO;
        if (in_user) begin
            rd_value = user_rd;
        end else if (in_cust) begin
            rd_value = cust_rd;
        end else begin
            case (addr_reg)
                ADDR_CTRL:       rd_value = ctrl_reg;
                ADDR_INT_STAT:   rd_value = stat_reg;
                ADDR_INT_MASK:   rd_value = mask_reg;
                ADDR_PROT_PROG:  rd_value = prot_reg;
                ADDR_UNLOCK_KEY: rd_value = (key_state_reg == KEY_UNLOCKED) ? KEY_READ_UNLOCKED
                                                                           : KEY_READ_LOCKED;
                default:         rd_value = BYTE_ZERO;
            endcase
        end
    end

    // miso shifts on synced sclk falls
    logic [7:0] tx_reg;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_reg        <= BYTE_ZERO;
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_oe_o <= frame_active;
            if (!frame_active) begin
                spi_miso_o <= 1'b0;
            end else if (sclk_fall) begin
                if (in_data_reg && (bit_cnt_reg == BIT_FIRST)) begin
                    spi_miso_o <= rd_value[7];
                    tx_reg     <= {rd_value[6:0], 1'b0};
                end else begin
                    spi_miso_o <= tx_reg[7];
                    tx_reg     <= {tx_reg[6:0], 1'b0};
                end
            end
        end
    end
endmodule : fault_shutdown_nvm_unlock

// >>> testbench/fault_shutdown_nvm_unlock_asserts.sv
// port assertions for the fault shutdown block
module fault_shutdown_nvm_unlock_asserts (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    // spi
    input wire logic       spi_cs_b_i,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe_o,
    // pin and fault flags
    input wire logic       projector_enable_pin_i,
    input wire logic       battery_low_shutdown_flag_i,
    input wire logic       thermal_shutdown_flag_i,
    input wire logic       thermal_warning_flag_i,
    input wire logic       mirror_power_good_fault_i,
    input wire logic       mirror_buck1_power_good_fault_i,
    input wire logic       mirror_buck1_overvoltage_fault_i,
    input wire logic       mirror_buck2_power_good_fault_i,
    input wire logic       mirror_buck2_overvoltage_fault_i,
    input wire logic [3:0] mirror_ldo_fault_i,
    input wire logic       illum_conv1_power_good_fault_i,
    input wire logic       illum_conv1_overvoltage_fault_i,
    input wire logic       illum_conv2_power_good_fault_i,
    input wire logic       illum_conv2_overvoltage_fault_i,
    // outputs
    input wire logic       fast_shutdown_o,
    input wire logic       orderly_shutdown_o,
    input wire logic       int_b_o,
    input wire logic       eeprom_program_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic       qual;
    logic       flt_any;
    logic [5:0] qual_reg;
    logic [5:0] flt_reg;
    logic [5:0] pin_reg;
    logic [7:0] cs_reg;
    // qualifying faults
    assign qual = battery_low_shutdown_flag_i | thermal_shutdown_flag_i | mirror_power_good_fault_i
                | mirror_buck1_power_good_fault_i | mirror_buck1_overvoltage_fault_i
                | mirror_buck2_power_good_fault_i | mirror_buck2_overvoltage_fault_i
                | (|mirror_ldo_fault_i) | illum_conv1_overvoltage_fault_i | illum_conv2_overvoltage_fault_i;
    assign flt_any = qual | thermal_warning_flag_i | illum_conv1_power_good_fault_i
                   | illum_conv2_power_good_fault_i;
    // recent causes, past synchronisers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            qual_reg <= 6'h00;
            flt_reg  <= 6'h00;
            pin_reg  <= 6'h00;
            cs_reg   <= 8'h00;
        end else begin
            qual_reg <= {qual_reg[4:0], qual};
            flt_reg  <= {flt_reg[4:0], flt_any};
            pin_reg  <= {pin_reg[4:0], !projector_enable_pin_i};
            cs_reg   <= {cs_reg[6:0], !spi_cs_b_i};
        end
    end
    sequence pin_low_held; !projector_enable_pin_i[*4]; endsequence
    sequence pin_high_held; projector_enable_pin_i[*4]; endsequence
    sequence cs_idle; spi_cs_b_i[*4]; endsequence
    sequence cs_active; !spi_cs_b_i[*4]; endsequence
    a_fast_needs_fault: assert property ($rose(fast_shutdown_o) |-> |qual_reg)
        else $error("fast shutdown without fault");
    a_fast_stays_latched: assert property ($fell(fast_shutdown_o) |-> |pin_reg)
        else $error("fast shutdown dropped, pin high");
    a_fast_off_pinlow: assert property (pin_low_held |=> !fast_shutdown_o)
        else $error("fast shutdown high, pin low");
    a_orderly_on_low: assert property (pin_low_held |=> orderly_shutdown_o)
        else $error("orderly shutdown missing");
    a_orderly_off_high: assert property (pin_high_held |=> !orderly_shutdown_o)
        else $error("orderly shutdown high, pin high");
    a_int_has_cause: assert property ($fell(int_b_o) |-> (|flt_reg) || (|cs_reg))
        else $error("interrupt without cause");
    a_miso_idle_off: assert property (cs_idle |=> !spi_miso_oe_o && !spi_miso_o)
        else $error("miso driven, cs high");
    a_miso_oe_on: assert property (cs_active |=> spi_miso_oe_o)
        else $error("miso off, cs low");
    a_prog_by_spi: assert property ($changed(eeprom_program_o) |-> |cs_reg)
        else $error("program changed without spi");
endmodule : fault_shutdown_nvm_unlock_asserts

bind fault_shutdown_nvm_unlock fault_shutdown_nvm_unlock_asserts u_asserts (.*);

// >>> testbench/spi_ctrl_model.sv
// spi controller model, two-byte frames
module spi_ctrl_model (
    input  wire logic clk_i,
    input  wire logic spi_miso_i,
    output logic      spi_sclk_o,
    output logic      spi_cs_b_o,
    output logic      spi_mosi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_b_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // 80 ns sclk, mode 0
    task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_mosi_o <= tx[i];
            repeat (4) @(posedge clk_i);
            spi_sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx[i] = spi_miso_i;
            spi_sclk_o <= 1'b0;
        end
    endtask : xfer_byte
    task automatic frame(input logic wr, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        logic [7:0] cmd_echo;
        @(posedge clk_i);
        spi_cs_b_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        xfer_byte({wr, addr}, cmd_echo);
        xfer_byte(wd, rd);
        repeat (4) @(posedge clk_i);
        spi_cs_b_o <= 1'b1;
        // released line shows inverse
        spi_mosi_o <= ~spi_mosi_o;
        repeat (8) @(posedge clk_i);
    endtask : frame
endmodule : spi_ctrl_model

// >>> testbench/tb.sv
// self-checking bench for the fault shutdown block
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fault_ctrl_pkg::*;
    localparam int          PROG_WAIT = 200;
    localparam logic [15:0] QUAL      = 16'haffb;
    localparam logic [6:0]  ALIST [6] = '{7'h02, 7'h09, 7'h01, 7'h0d, 7'h30, 7'h10};
    logic        clk;
    logic        rst_b;
    logic        sclk;
    logic        cs_b;
    logic        mosi;
    logic        miso;
    logic        pin;
    logic [15:0] flt;
    logic        fast;
    logic        orderly;
    logic        int_b;
    logic        prog;
    logic [7:0]  mreg [128];
    logic        unl;
    logic        half;
    logic [7:0]  rd_val;
    logic [7:0]  d;
    int          seed;
    int          fail_count;
    int          check_count;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    fault_shutdown_nvm_unlock u_dut (
        .clk_i(clk), .rst_b_i(rst_b), .spi_sclk_i(sclk), .spi_cs_b_i(cs_b), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(), .projector_enable_pin_i(pin),
        .battery_low_shutdown_flag_i(flt[0]), .thermal_shutdown_flag_i(flt[1]),
        .thermal_warning_flag_i(flt[2]), .mirror_power_good_fault_i(flt[3]),
        .mirror_buck1_power_good_fault_i(flt[4]), .mirror_buck1_overvoltage_fault_i(flt[5]),
        .mirror_buck2_power_good_fault_i(flt[6]), .mirror_buck2_overvoltage_fault_i(flt[7]),
        .mirror_ldo_fault_i(flt[11:8]), .illum_conv1_power_good_fault_i(flt[12]),
        .illum_conv1_overvoltage_fault_i(flt[13]), .illum_conv2_power_good_fault_i(flt[14]),
        .illum_conv2_overvoltage_fault_i(flt[15]), .fast_shutdown_o(fast),
        .orderly_shutdown_o(orderly), .int_b_o(int_b), .eeprom_program_o(prog));
    spi_ctrl_model u_ctrl (.clk_i(clk), .spi_miso_i(miso), .spi_sclk_o(sclk), .spi_cs_b_o(cs_b), .spi_mosi_o(mosi));
    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (mreg[i]) mreg[i] = 8'h00;
        mreg[ADDR_CTRL] = CTRL_RESET;
        unl = 1'b0;
        half = 1'b0;
    endtask : pulse_reset
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        logic ok;
        ok = !mreg[ADDR_PROT_PROG][PROTECT_BIT] || a inside {[ADDR_USER_LO:ADDR_USER_HI]} || a == ADDR_PROT_PROG;
        if (a == ADDR_UNLOCK_KEY) begin
            unl = ok ? (half && v == KEY_SECOND) : unl;
            half = ok ? (v == KEY_FIRST) : half;
        end else begin
            half = 1'b0;
            if (ok && a == ADDR_INT_STAT) mreg[a] = mreg[a] & ~v;
            else if (ok && a inside {[ADDR_CUST_LO:ADDR_CUST_HI]}) mreg[a] = unl ? v : mreg[a];
            else if (ok && a inside {ADDR_CTRL, ADDR_INT_MASK, ADDR_PROT_PROG, [ADDR_USER_LO:ADDR_USER_HI]}) mreg[a] = v;
        end
        u_ctrl.frame(1'b1, a, v, rd_val);
    endtask : wr
    task automatic rd(input logic [6:0] a);
        logic [7:0] exp;
        exp = (a == ADDR_UNLOCK_KEY) ? (unl ? KEY_READ_UNLOCKED : KEY_READ_LOCKED) : mreg[a];
        half = 1'b0;
        u_ctrl.frame(1'b0, a, 8'h00, rd_val);
        chk(rd_val, exp);
    endtask : rd
    // watchdog
    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        seed = 32'ha86af5cc;
        fail_count = 0;
        check_count = 0;
        rst_b = 1'b0;
        pin = 1'b1;
        flt = 16'h0000;
        pulse_reset();
        rd(ADDR_CTRL);
        rd(ADDR_PROT_PROG);
        rd(ADDR_UNLOCK_KEY);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_PROT_PROG, 8'(p));
            foreach (ALIST[k]) begin
                d = 8'($random(seed));
                if (ALIST[k] == ADDR_CTRL) d = 8'(p);
                if (ALIST[k] == ADDR_INT_MASK) d = {3'h0, ~mreg[ADDR_INT_MASK][4:0]};
                wr(ALIST[k], d);
            end
            foreach (ALIST[k]) rd(ALIST[k]);
        end
        wr(ADDR_PROT_PROG, 8'h00);
        rd(ADDR_PROT_PROG);
        wr(ADDR_UNLOCK_KEY, KEY_FIRST);
        rd(ADDR_USER_LO);
        wr(ADDR_UNLOCK_KEY, KEY_SECOND);
        rd(ADDR_UNLOCK_KEY);
        wr(ADDR_UNLOCK_KEY, KEY_FIRST);
        wr(ADDR_UNLOCK_KEY, KEY_SECOND);
        rd(ADDR_UNLOCK_KEY);
        for (logic [6:0] a = ADDR_CUST_LO; a <= ADDR_CUST_HI; a++) wr(a, 8'($random(seed)));
        for (logic [6:0] a = ADDR_CUST_LO; a <= ADDR_CUST_HI; a++) rd(a);
        wr(ADDR_PROT_PROG, 8'(1 << PROGRAM_BIT));
        chk(8'(prog), 8'h01);
        repeat (PROG_WAIT) @(posedge clk);
        wr(ADDR_PROT_PROG, 8'h00);
        chk(8'(prog), 8'h00);
        wr(ADDR_UNLOCK_KEY, 8'h11);
        rd(ADDR_UNLOCK_KEY);
        wr(ADDR_CUST_HI, ~mreg[ADDR_CUST_HI]);
        rd(ADDR_CUST_HI);
        wr(ADDR_UNLOCK_KEY, KEY_FIRST);
        wr(ADDR_UNLOCK_KEY, KEY_SECOND);
        pulse_reset();
        rd(ADDR_UNLOCK_KEY);
        for (int i = 0; i < 16; i++) begin
            flt <= 16'(1 << i);
            repeat (10) @(posedge clk);
            chk(8'(fast), 8'(QUAL[i]));
            chk(8'(int_b), 8'h00);
            flt <= 16'h0000;
            mreg[ADDR_INT_STAT] = 8'(1 << (i < 3 ? i : (i < 12 ? INT_MIRROR : INT_ILLUM)));
            rd(ADDR_INT_STAT);
            chk(8'(fast), 8'(QUAL[i]));
            pin <= 1'b0;
            repeat (8) @(posedge clk);
            chk(8'(fast), 8'h00);
            chk(8'(orderly), 8'h01);
            pin <= 1'b1;
            wr(ADDR_INT_STAT, 8'h1f);
            chk(8'(int_b), 8'h01);
        end
        wr(ADDR_INT_MASK, 8'h1f);
        wr(ADDR_CTRL, 8'h00);
        flt <= 16'h0001;
        repeat (10) @(posedge clk);
        chk(8'(fast), 8'h00);
        chk(8'(int_b), 8'h01);
        flt <= 16'h0000;
        mreg[ADDR_INT_STAT] = 8'h01;
        wr(ADDR_INT_STAT, 8'h1f);
        wr(ADDR_INT_MASK, 8'h00);
        chk(8'(int_b), 8'h01);
        report_and_stop();
    end
endmodule : tb
